/* hw/thl_map.vh */
/*
 * register offsets, field positions, reset values and fixed levels of the
 * thermal overload trip logic. assumes a 32-bit apb with byte addresses.
 */
`ifndef THL_MAP_VH
`define THL_MAP_VH

// register byte offsets
`define THL_OFF_CTRL 8'h00
`define THL_OFF_STATUS 8'h04
`define THL_OFF_HEAT 8'h08
`define THL_OFF_GRPSW 8'h0c
`define THL_OFF_TMAX 8'h10
`define THL_OFF_SAVED 8'h14
// per-group window: group a at 0x20, group b at 0x30 (address bits 7:4)
`define THL_GRP_A 4'h2
`define THL_GRP_B 4'h3
`define THL_GRP_ALARM 2'h0
`define THL_GRP_TRIP 2'h1
`define THL_GRP_INIT 2'h2
`define THL_GRP_TC 2'h3

// ctrl fields
`define THL_CTRL_K_LO 0
`define THL_CTRL_K_HI 1
`define THL_CTRL_MOTOR 2
`define THL_CTRL_INH 3
`define THL_CTRL_ENA 4
// tmax fields
`define THL_TMAX_AMB_EN 8

// reset values (heat in q8.16, 1.0 = 100 %)
`define THL_RST_ALARM 18'h0e666
`define THL_RST_TRIP 18'h1199a
`define THL_RST_INIT 18'h00000
`define THL_RST_HEAT_TC 16'h0001
`define THL_RST_COOL_TC 16'h0005
`define THL_RST_GRPSW 16'h2000
`define THL_RST_TMAX 8'h78

// fixed levels
`define THL_RUN_LEVEL 16'h019a
`define THL_HOT_LEVEL 24'h008000
`define THL_AMB_REF 8'h28
`define THL_ONE_Q16 19'h10000
`define THL_FA_MAX 19'h40000
`define THL_HEAT_MAX 24'hffffff

// timing: sample period in us, microseconds in one minute
`define THL_SAMPLE_US 16'h03e8
`define THL_US_PER_MIN 27'h3938700

`endif

/* hw/thl_divider.v */
/*
 * serial restoring divider, one quotient bit per clock.
 * assumes start only while idle; den of zero gives an all-ones quotient.
 */
`timescale 1ns/1ps

module thl_divider #(
    parameter W = 48
) (
    input wire clk,
    input wire rst_n,
    input wire start,
    input wire [W-1:0] num,
    input wire [W-1:0] den,
    output reg done,
    output reg [W-1:0] quot
);

// partial remainder, one bit wider than the operands
reg [W:0] rem;
reg [W-1:0] dvs;
reg [$clog2(W+1)-1:0] cnt;
wire [W:0] shifted = {rem[W-1:0], quot[W-1]};
wire fits = shifted >= {1'b0, dvs};

////////////////////////////////////////////////////////////////////////
// iterate; quotient bits shift into quot as dividend bits leave it
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        rem <= {(W+1){1'b0}};
        dvs <= {W{1'b0}};
        quot <= {W{1'b0}};
        cnt <= {($clog2(W+1)){1'b0}};
        done <= 1'b0;
    end
    else
    begin
        done <= 1'b0;
        if (start)
        begin
            rem <= {(W+1){1'b0}};
            dvs <= den;
            quot <= num;
            cnt <= W[$clog2(W+1)-1:0];
        end
        else if (cnt != {($clog2(W+1)){1'b0}})
        begin
            // subtract when the divisor fits
            rem <= fits ? (shifted - {1'b0, dvs}) : shifted;
            quot <= {quot[W-2:0], fits};
            cnt <= cnt - 1'b1;
            done <= (cnt == 1);
        end
    end
end

endmodule // thl_divider

/* hw/thl_trip_logic.v */
/*
 * thermal overload trip logic: heat rise integrator, alarm, trip, hot
 * state, start inhibit and trip-time heat saving, set up over apb.
 * assumes per-unit currents (q4.12, 1.0 = basis current) from a true rms
 * front end on clk, and a power-fail-safe store outside.
 */
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "thl_map.vh"

module thl_trip_logic #(
    parameter SAMPLE_US = `THL_SAMPLE_US
) (
    input wire clk,
    input wire rst_n,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire sample_valid,
    input wire [15:0] phase_current_a,
    input wire [15:0] phase_current_b,
    input wire [15:0] phase_current_c,
    input wire [15:0] negative_sequence_current,
    input wire signed [7:0] ambient_temp,
    input wire thermal_inhibit_input,
    input wire nv_restore_valid,
    input wire [23:0] nv_restore_heat,
    output reg alarm_out,
    output reg trip_out,
    output reg hot_state_out,
    output reg start_inhibit_out,
    output reg nv_save_write,
    output reg [23:0] nv_save_heat
);

// one-hot sequencer states
localparam [5:0] S_INIT = 6'h01;
localparam [5:0] S_IDLE = 6'h02;
localparam [5:0] S_DFA = 6'h04;
localparam [5:0] S_DAL = 6'h08;
localparam [5:0] S_UPD = 6'h10;
localparam [5:0] S_CMP = 6'h20;

////////////////////////////////////////////////////////////////////////
// apb access decode; one wait state, write lands with pready high
wire acc = psel & penable;
wire wr_en = acc & pwrite & pready;
wire ctrl_wr = wr_en & (paddr == `THL_OFF_CTRL);

// configuration state
reg [1:0] k_sel; // negative sequence weight code
reg motor_mode; // motor application
reg remote_inh; // remote inhibit latched
reg [15:0] group_sw; // group switch current, per unit
reg [7:0] tmax; // equipment maximum temperature
reg amb_en; // ambient channel fitted
reg [17:0] alarm_thr [0:1];
reg [17:0] trip_thr [0:1];
reg [17:0] init_off [0:1];
reg [15:0] heat_tc [0:1]; // minutes
reg [15:0] cool_tc [0:1]; // minutes

// inhibit pin synchroniser
reg inh_m;
reg inh_s;
wire inhibited = inh_s | remote_inh;

// datapath state
reg [5:0] state;
reg [15:0] iph; // greatest phase current
reg [15:0] ineg; // negative sequence current
reg running;
reg grp; // active parameter group
reg [18:0] fa; // ambient factor, q.16
reg [31:0] alpha; // sample period over time constant, q0.32
reg [23:0] heat; // heat rise, q8.16
wire [23:0] heat_eff; // ambient-scaled heat rise, read by the register mux
reg ready;
reg div_start;
reg [47:0] div_num;
reg [47:0] div_den;
wire div_done;
wire [47:0] div_q;

////////////////////////////////////////////////////////////////////////
// control register and remote commands; the inhibit command wins
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        k_sel <= 2'h0;
        motor_mode <= 1'b0;
        remote_inh <= 1'b0;
        group_sw <= `THL_RST_GRPSW;
        tmax <= `THL_RST_TMAX;
        amb_en <= 1'b0;
    end
    else
    begin
        if (ctrl_wr)
        begin
            k_sel <= pwdata[`THL_CTRL_K_HI:`THL_CTRL_K_LO];
            motor_mode <= pwdata[`THL_CTRL_MOTOR];
            if (pwdata[`THL_CTRL_INH])
                remote_inh <= 1'b1;
            else if (pwdata[`THL_CTRL_ENA])
                remote_inh <= 1'b0;
        end
        if (wr_en && paddr == `THL_OFF_GRPSW)
            group_sw <= pwdata[15:0];
        if (wr_en && paddr == `THL_OFF_TMAX)
        begin
            tmax <= pwdata[7:0];
            amb_en <= pwdata[`THL_TMAX_AMB_EN];
        end
    end
end

////////////////////////////////////////////////////////////////////////
// two parameter groups, same layout at consecutive windows
genvar g;
generate
    for (g = 0; g < 2; g = g + 1)
    begin : grp_regs
        localparam [3:0] GSEL = (g == 0) ? `THL_GRP_A : `THL_GRP_B;
        always @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                alarm_thr[g] <= `THL_RST_ALARM;
                trip_thr[g] <= `THL_RST_TRIP;
                init_off[g] <= `THL_RST_INIT;
                heat_tc[g] <= `THL_RST_HEAT_TC;
                cool_tc[g] <= `THL_RST_COOL_TC;
            end
            else if (wr_en && paddr[7:4] == GSEL)
            begin
                case (paddr[3:2])
                    `THL_GRP_ALARM: alarm_thr[g] <= pwdata[17:0];
                    `THL_GRP_TRIP: trip_thr[g] <= pwdata[17:0];
                    `THL_GRP_INIT: init_off[g] <= pwdata[17:0];
                    default:
                    begin
                        // range limits are left to software
                        heat_tc[g] <= pwdata[15:0];
                        cool_tc[g] <= pwdata[31:16];
                    end
                endcase
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////
// read mux; unmapped addresses answer zero with pslverr
reg [31:0] next_prdata;
reg next_err;
always @*
begin
    next_prdata = 32'h0;
    next_err = 1'b0;
    case (paddr[7:4])
        `THL_GRP_A, `THL_GRP_B:
        begin
            case (paddr[3:2])
                `THL_GRP_ALARM: next_prdata = {14'h0, alarm_thr[paddr[4]]};
                `THL_GRP_TRIP: next_prdata = {14'h0, trip_thr[paddr[4]]};
                `THL_GRP_INIT: next_prdata = {14'h0, init_off[paddr[4]]};
                default: next_prdata = {cool_tc[paddr[4]], heat_tc[paddr[4]]};
            endcase
        end
        default:
        begin
            case (paddr)
                `THL_OFF_CTRL: next_prdata = {28'h0, remote_inh, motor_mode, k_sel};
                `THL_OFF_STATUS: next_prdata = {24'h0, ready, inhibited,
                    start_inhibit_out, grp, running, hot_state_out, trip_out,
                    alarm_out};
                `THL_OFF_HEAT: next_prdata = {8'h0, heat_eff};
                `THL_OFF_GRPSW: next_prdata = {16'h0, group_sw};
                `THL_OFF_TMAX: next_prdata = {23'h0, amb_en, tmax};
                `THL_OFF_SAVED: next_prdata = {8'h0, nv_save_heat};
                default: next_err = 1'b1;
            endcase
        end
    endcase
end

// answer registered one cycle into the access phase
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        pready <= 1'b0;
        prdata <= 32'h0;
        pslverr <= 1'b0;
    end
    else
    begin
        pready <= acc & ~pready;
        prdata <= (acc & ~pready & ~pwrite) ? next_prdata : 32'h0;
        pslverr <= acc & ~pready & next_err;
    end
end

////////////////////////////////////////////////////////////////////////
// inhibit pin crosses in on two flops
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        inh_m <= 1'b0;
        inh_s <= 1'b0;
    end
    else
    begin
        inh_m <= thermal_inhibit_input;
        inh_s <= inh_m;
    end
end

////////////////////////////////////////////////////////////////////////
// arithmetic
// greatest phase current of the rms inputs
wire [15:0] max_ab = (phase_current_a > phase_current_b) ?
    phase_current_a : phase_current_b;
wire [15:0] max_abc = (max_ab > phase_current_c) ? max_ab : phase_current_c;

// squared equivalent current; 2.25 and 4.5 are nine shifted down
wire [31:0] iph_sq = iph * iph;
wire [31:0] ineg_sq = ineg * ineg;
wire [35:0] ineg9 = {ineg_sq, 3'b000} + {4'h0, ineg_sq};
reg [35:0] kterm;
always @*
begin
    case (k_sel)
        2'h1: kterm = {2'b00, ineg9[35:2]};
        2'h2: kterm = {1'b0, ineg9[35:1]};
        2'h3: kterm = ineg9;
        default: kterm = 36'h0;
    endcase
end
wire [36:0] ieq_sq = {5'h0, iph_sq} + {1'b0, kterm};
// q8.24 to q8.16, saturating; this is the steady heat target
wire [23:0] target = (|ieq_sq[36:32]) ? `THL_HEAT_MAX : ieq_sq[31:8];

// first-order step; alpha below one so the step never overshoots
wire signed [24:0] diff = $signed({1'b0, target}) - $signed({1'b0, heat});
wire signed [57:0] prod = diff * $signed({1'b0, alpha});
wire signed [25:0] step = prod[57:32];
wire [25:0] hsum = {2'b00, heat} + step;

// ambient-scaled heat rise, seen by every comparison
wire [42:0] heff_w = heat * fa;
assign heat_eff = (|heff_w[42:40]) ? `THL_HEAT_MAX : heff_w[39:16];

// heat rise with ten percent starting heat added
wire [24:0] heat_plus = {1'b0, heat_eff} + {1'b0, heat_eff / 24'd10};
wire [23:0] heat_save = heat_plus[24] ? `THL_HEAT_MAX : heat_plus[23:0];
wire restart_blocked = heat_plus > {7'h0, trip_thr[grp]};

// division operands; ambient off gives factor 1.0
wire amb_hot = amb_en && (ambient_temp > $signed(`THL_AMB_REF));
wire [7:0] amb_u = ambient_temp[7:0];
wire [7:0] fa_den = (tmax > amb_u) ? (tmax - amb_u) : 8'h01;
wire [15:0] tc_sel = running ? heat_tc[grp] : cool_tc[grp];
wire [42:0] us_per_tc = tc_sel * `THL_US_PER_MIN;

thl_divider #(
    .W(48)
) u_div (
    .clk(clk),
    .rst_n(rst_n),
    .start(div_start),
    .num(div_num),
    .den(div_den),
    .done(div_done),
    .quot(div_q)
);

////////////////////////////////////////////////////////////////////////
// sample sequencer: latch, ambient factor, coefficient, step, compare
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        state <= S_INIT;
        iph <= 16'h0;
        ineg <= 16'h0;
        running <= 1'b0;
        grp <= 1'b0;
        fa <= `THL_ONE_Q16;
        alpha <= 32'h0;
        heat <= 24'h0;
        ready <= 1'b0;
        div_start <= 1'b0;
        div_num <= 48'h0;
        div_den <= 48'h0;
        alarm_out <= 1'b0;
        trip_out <= 1'b0;
        hot_state_out <= 1'b0;
        start_inhibit_out <= 1'b0;
        nv_save_write <= 1'b0;
        nv_save_heat <= 24'h0;
    end
    else
    begin
        div_start <= 1'b0;
        nv_save_write <= 1'b0;
        case (state)
            S_INIT:
            begin
                // wait for the store; cold start begins at the offset
                if (nv_restore_valid)
                begin
                    if (nv_restore_heat > {6'h0, init_off[0]})
                        heat <= nv_restore_heat;
                    else
                        heat <= {6'h0, init_off[0]};
                    nv_save_heat <= nv_restore_heat;
                    ready <= 1'b1;
                    state <= S_IDLE;
                end
            end
            S_IDLE:
            begin
                if (sample_valid)
                begin
                    // rms inputs carry harmonics to the 17th
                    iph <= max_abc;
                    ineg <= negative_sequence_current;
                    // exactly a tenth keeps the previous state
                    if (max_abc > `THL_RUN_LEVEL)
                        running <= 1'b1;
                    else if (max_abc < `THL_RUN_LEVEL)
                        running <= 1'b0;
                    // heat is left alone on a group change
                    grp <= max_abc > group_sw;
                    if (amb_hot)
                    begin
                        div_num <= {24'h0, tmax - `THL_AMB_REF, 16'h0000};
                        div_den <= {40'h0, fa_den};
                    end
                    else
                    begin
                        div_num <= 48'h10000;
                        div_den <= 48'h1;
                    end
                    div_start <= 1'b1;
                    state <= S_DFA;
                end
            end
            S_DFA:
            begin
                if (div_done)
                begin
                    fa <= (div_q > {29'h0, `THL_FA_MAX}) ? `THL_FA_MAX :
                        div_q[18:0];
                    div_num <= {SAMPLE_US, 32'h0};
                    div_den <= {5'h0, us_per_tc};
                    div_start <= 1'b1;
                    state <= S_DAL;
                end
            end
            S_DAL:
            begin
                if (div_done)
                begin
                    // zero constant saturates: heat jumps to target
                    alpha <= (|div_q[47:32]) ? 32'hffffffff : div_q[31:0];
                    state <= S_UPD;
                end
            end
            S_UPD:
            begin
                heat <= hsum[23:0];
                state <= S_CMP;
            end
            default:
            begin
                alarm_out <= heat_eff > {6'h0, alarm_thr[grp]};
                trip_out <= (heat_eff > {6'h0, trip_thr[grp]}) & ~inhibited;
                hot_state_out <= motor_mode & (heat_eff > `THL_HOT_LEVEL);
                start_inhibit_out <= motor_mode & restart_blocked;
                // a new trip wins over the clear
                if ((heat_eff > {6'h0, trip_thr[grp]}) && !inhibited && !trip_out)
                begin
                    nv_save_heat <= heat_save;
                    nv_save_write <= 1'b1;
                end
                else if (!restart_blocked && nv_save_heat != 24'h0)
                begin
                    nv_save_heat <= 24'h0;
                    nv_save_write <= 1'b1;
                end
                state <= S_IDLE;
            end
        endcase
    end
end

endmodule // thl_trip_logic

/* sim/thl_trip_logic_chk.sv */
/* checker for the thermal overload trip logic: apb timing and flag,
   save and clear relations. assumes it is bound to the top ports. */
`timescale 1ns/1ps
//////////////////////////////////////////
module thl_chk (
    input wire clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire [31:0] prdata,
    input wire sample_valid,
    input wire alarm_out,
    input wire trip_out,
    input wire hot_state_out,
    input wire nv_save_write,
    input wire [23:0] nv_save_heat
);
    // cycles since the last sample pulse, parked at ff when none
    reg [7:0] since;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            since <= 8'hff;
        else if (sample_valid)
            since <= 8'h00;
        else if (since != 8'hff)
            since <= since + 8'h01;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ready_timing_a: assert property ($rose(penable) && psel |=> pready)
        else $error("pready late after access start");
    ready_single_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_phase_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero while idle");
    // flags may only move at the end of a sample update
    flag_timing_a: assert property (!$stable({alarm_out, trip_out, hot_state_out}) |->
        since >= 8'd90 && since <= 8'd120)
        else $error("flag moved outside a sample update");
    trip_save_a: assert property ($rose(trip_out) |-> ##[0:1]
        (nv_save_write && nv_save_heat != 24'h0))
        else $error("no heat saved at trip");
    save_pulse_a: assert property (nv_save_write |=> !nv_save_write)
        else $error("save strobe too long");
    save_clear_a: assert property (nv_save_write && nv_save_heat == 24'h0 |-> !trip_out)
        else $error("saved heat cleared while tripped");
endmodule // thl_chk

/* sim/thl_front_end.sv */
/* measurement front end model: per-unit rms currents, ambient and the
   power-fail-safe restore. assumes the bench calls its tasks. */
`timescale 1ns/1ps
//////////////////////////////////////////
module thl_front_end (
    input wire clk,
    output reg sv,
    output reg [15:0] pa,
    output reg [15:0] pb,
    output reg [15:0] pc,
    output reg [15:0] ng,
    output reg [7:0] amb,
    output reg rv,
    output reg [23:0] rh
);
    integer rot = 0; // which phase carries the largest current
    initial
    begin
        sv = 0;
        pa = 0;
        pb = 0;
        pc = 0;
        ng = 0;
        amb = 8'd25;
        rv = 0;
        rh = 0;
    end
    // one sample, then quiet past the update time
    task send(input [15:0] ph, input [15:0] neg, input [7:0] t);
    begin
        @(posedge clk);
        rot = (rot + 1) % 3;
        pa <= (rot == 0) ? ph : ph >> 1;
        pb <= (rot == 1) ? ph : ph >> 1;
        pc <= (rot == 2) ? ph : ph >> 1;
        ng <= neg;
        amb <= t;
        sv <= 1'b1;
        @(posedge clk);
        sv <= 1'b0;
        repeat (120) @(posedge clk);
    end
    endtask
    // stored heat offered once after reset
    task restore(input [23:0] h);
    begin
        @(posedge clk);
        rv <= 1'b1;
        rh <= h;
        @(posedge clk);
        rv <= 1'b0;
        rh <= ~h;
    end
    endtask
endmodule // thl_front_end

/* sim/thl_trip_logic_tb.sv */
/* bench for the thermal overload trip logic: registers, heat levels,
   trip save, inhibit, groups, weighting. assumes the model and checker. */
`timescale 1ns/1ps
`include "thl_map.vh"
module thl_trip_logic_tb;
    reg clk = 0;
    reg rst_n = 0;
    reg [7:0] paddr = 8'h00;
    reg psel = 0;
    reg penable = 0;
    reg pwrite = 0;
    reg [31:0] pwdata = 32'h0;
    reg inh = 0;
    wire [31:0] prdata;
    wire pready, pslverr, sv, rv, al, tr, hs, si, sw;
    wire [15:0] pa, pb, pc, ng;
    wire [7:0] amb;
    wire [23:0] rh, sh;
    integer errors = 0;
    integer checks = 0;
    integer seed = 32;
    integer i, k;
    reg [31:0] q, h0;
    reg er;
    reg [16:0] h;
    reg [7:0] t;
    reg [23:0] saved = 24'h0; // last value sent to the store
    real e;
    localparam [47:0] RA = {8'h0c, 8'h10, 8'h20, 8'h24, 8'h28, 8'h2c};
    localparam [191:0] RV = {32'h2000, 32'h78, 32'he666, 32'h1199a, 32'h0, 32'h50001};
    thl_trip_logic dut (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sample_valid(sv), .phase_current_a(pa),
        .phase_current_b(pb), .phase_current_c(pc), .negative_sequence_current(ng),
        .ambient_temp(amb), .thermal_inhibit_input(inh), .nv_restore_valid(rv),
        .nv_restore_heat(rh), .alarm_out(al), .trip_out(tr), .hot_state_out(hs),
        .start_inhibit_out(si), .nv_save_write(sw), .nv_save_heat(sh));
    thl_front_end fe (.clk(clk), .sv(sv), .pa(pa), .pb(pb), .pc(pc), .ng(ng),
        .amb(amb), .rv(rv), .rh(rh));
    initial
    begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (sw === 1'b1)
            saved <= sh;
    end
    //////////////////////////////////////////
    task end_of_test;
    begin
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    task chk(input [8*10:1] nm, input [31:0] ex, input [31:0] got);
    begin
        checks = checks + 1;
        if (got !== ex)
        begin
            errors = errors + 1;
            $display("wrong value %0s expected %h seen %h", nm, ex, got);
        end
    end
    endtask
    // fixed-point heat path only matches within a tolerance
    task near(input [8*10:1] nm, input real ex, input [31:0] got, input real tol);
    begin
        checks = checks + 1;
        if (^got === 1'bx || got - ex > tol || ex - got > tol)
        begin
            errors = errors + 1;
            $display("wrong value %0s expected %0.1f seen %h", nm, ex, got);
        end
    end
    endtask
    // skip levels too close to a threshold for rounding to decide
    task fchk(input [8*10:1] nm, input real he, input real thr, input got);
    begin
        if (he > thr + 800 || he < thr - 800)
            chk(nm, he > thr, got);
    end
    endtask
    task flags(input real he, input real tl);
    begin
        fchk("alarm", he, 58982.0, al);
        fchk("trip", he, tl, tr);
        fchk("hot", he, 32768.0, hs);
    end
    endtask
    function real eff(input real hh, input integer tt);
    begin
        eff = (tt > 40) ? hh * 80.0 / (120 - tt) : hh;
    end
    endfunction
    task apb(input w, input [7:0] a, input [31:0] d);
        integer n;
    begin
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20)
        begin
            n = n + 1;
            @(posedge clk);
        end
        q = prdata;
        er = pslverr;
        if (n == 20)
        begin
            errors = errors + 1;
            end_of_test;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask
    task rst;
    begin
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
    end
    endtask
    //////////////////////////////////////////
    initial
    begin
        repeat (100000) @(posedge clk);
        errors = errors + 1;
        end_of_test;
    end
    initial
    begin
        rst;
        for (i = 0; i < 6; i = i + 1)
        begin
            apb(0, RA[8*i +: 8], 0);
            chk("reset", RV[32*i +: 32], q);
        end
        apb(0, 8'hfc, 0);
        chk("unmapped", 1, er);
        chk("unm data", 0, q);
        $display("registers done");
        // random restored heat and ambient, first case a scaled trip
        for (i = 0; i < 8; i = i + 1)
        begin
            q = $random(seed);
            h = (i == 0) ? 17'h0cccd : q[16:0];
            q = $random(seed);
            t = (i < 2) ? 8'd80 : 8'd20 + {2'b0, q[5:0]};
            rst;
            apb(1, `THL_OFF_TMAX, 32'h178);
            apb(1, `THL_OFF_CTRL, 32'h4);
            fe.restore({7'h0, h});
            fe.send(16'h1000, 16'h0, t);
            e = eff(h, t);
            apb(0, `THL_OFF_HEAT, 0);
            near("heat", e, q, e / 128 + 4);
            flags(e, 72090.0);
        end
        $display("heat levels done");
        rst;
        apb(1, `THL_OFF_CTRL, 32'h4);
        fe.restore(24'h14000);
        fe.send(16'h1000, 16'h0, 8'd25);
        flags(81920.0, 72090.0);
        chk("start inh", 1, si);
        near("saved", 90112.0, saved, 700);
        apb(0, `THL_OFF_SAVED, 0);
        near("saved reg", 90112.0, q, 700);
        apb(1, 8'h24, 32'h20000);
        fe.send(16'h1000, 16'h0, 8'd25);
        chk("trip", 0, tr);
        chk("start inh", 0, si);
        chk("saved", 0, saved);
        $display("save done");
        rst;
        apb(1, `THL_OFF_CTRL, 32'hc);
        fe.restore(24'h14000);
        fe.send(16'h1000, 16'h0, 8'd25);
        chk("trip", 0, tr);
        apb(0, `THL_OFF_STATUS, 0);
        chk("inhibited", 1, q[6]);
        inh <= 1'b1;
        apb(1, `THL_OFF_CTRL, 32'h14);
        fe.send(16'h1000, 16'h0, 8'd25);
        chk("trip", 0, tr);
        inh <= 1'b0;
        fe.send(16'h1000, 16'h0, 8'd25);
        chk("trip", 1, tr);
        $display("inhibit done");
        rst;
        apb(1, 8'h34, 32'h30000);
        apb(1, `THL_OFF_CTRL, 32'h4);
        fe.restore(24'h18000);
        fe.send(16'h1000, 16'h0, 8'd25);
        chk("trip a", 1, tr);
        fe.send(16'h3000, 16'h0, 8'd25);
        chk("trip b", 0, tr);
        apb(0, `THL_OFF_STATUS, 0);
        chk("group", 1, q[4]);
        apb(0, `THL_OFF_HEAT, 0);
        near("heat kept", 98304.0, q, 64);
        fe.send(16'h019b, 16'h0, 8'd25);
        apb(0, `THL_OFF_STATUS, 0);
        chk("running", 1, q[3]);
        fe.send(16'h0199, 16'h0, 8'd25);
        apb(0, `THL_OFF_STATUS, 0);
        chk("stopped", 0, q[3]);
        $display("groups done");
        // one heating step per weighting code, from the 0x8000 initial offset
        rst;
        apb(1, 8'h2c, 32'h00050001);
        apb(1, 8'h28, 32'h8000);
        fe.restore(24'h0);
        apb(0, `THL_OFF_HEAT, 0);
        chk("init heat", 32'h8000, q);
        for (k = 0; k < 4; k = k + 1)
        begin
            apb(1, `THL_OFF_CTRL, k);
            apb(0, `THL_OFF_HEAT, 0);
            h0 = q;
            fe.send(16'h4000, 16'h4000, 8'd25);
            apb(0, `THL_OFF_HEAT, 0);
            e = ((k == 3) ? 9.0 : k * 2.25) * 16.0 + 16.0;
            e = (e * 65536.0 - h0) / 60000.0;
            near("k step", e, q - h0, e / 5 + 2);
        end
        $display("weighting done");
        end_of_test;
    end
endmodule // thl_trip_logic_tb
bind thl_trip_logic thl_chk chk (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .sample_valid(sample_valid), .alarm_out(alarm_out), .trip_out(trip_out),
    .hot_state_out(hot_state_out), .nv_save_write(nv_save_write),
    .nv_save_heat(nv_save_heat));
